// ==== hdl/lsf_pkg.sv ====
/*
  Constants for the link status flags register: offset, field positions,
  reset value and masks.
  Assumes a 16-bit configuration access port addressed by byte offset.
*/
package lsf_pkg;

  // ==========================================================
  // Widths and offset
  localparam int LSF_DATA_W = 16;
  localparam int LSF_ADDR_W = 8;
  localparam logic [LSF_ADDR_W-1:0] LSF_STATUS_OFFSET = 8'h06;

  // ==========================================================
  // Field positions
  localparam int LSF_POISONED_RX_BIT = 15;
  localparam int LSF_ERR_MSG_SENT_BIT = 14;
  localparam int LSF_UNSUP_CPL_RX_BIT = 13;
  localparam int LSF_CA_RX_BIT = 12;
  localparam int LSF_CA_TX_BIT = 11;
  localparam int LSF_DEVSEL_HI_BIT = 10;
  localparam int LSF_DEVSEL_LO_BIT = 9;
  localparam int LSF_DATA_POISON_BIT = 8;
  localparam int LSF_BACK_TO_BACK_BIT = 7;
  localparam int LSF_RSVD6_BIT = 6;
  localparam int LSF_FAST_BUS_BIT = 5;
  localparam int LSF_CAP_CHAIN_BIT = 4;
  localparam int LSF_INT_STATUS_BIT = 3;
  localparam int LSF_HI_BYTE_LANE = 1;

  // ==========================================================
  // Values and masks
  localparam logic [LSF_DATA_W-1:0] LSF_RESET_VALUE = 16'h0010;
  localparam logic [LSF_DATA_W-1:0] LSF_CONST_VALUE = 16'h0010;
  localparam logic [LSF_DATA_W-1:0] LSF_STICKY_MASK = 16'hf900;
  localparam logic [LSF_DATA_W-1:0] LSF_ZERO = 16'h0000;
  localparam logic [1:0] LSF_DEVSEL_VALUE = 2'h0;

endpackage

// ==== hdl/lsf_sticky_bank.sv ====
/*
  Bank of sticky flags: a set input per bit, a clear input per bit.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module lsf_sticky_bank #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Flag control
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clear_i,
  // Flag state
  output logic [WIDTH-1:0] flags_o
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } lsf_bank_state_type;

  lsf_bank_state_type state_reg;
  lsf_bank_state_type state_next;

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    // Set wins so an event in the clearing cycle is kept
    state_next.flags = (state_reg.flags & ~clear_i) | set_i;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags_o = state_reg.flags;

endmodule

`default_nettype wire

// ==== hdl/lsf_status_reg.sv ====
/*
  Link status flags register of a PCI Express to PCI bridge function.
  Sticky error flags, hardwired capability bits, configuration access port.
  Assumes event strobes and command enables come from logic on core_clk_i,
  one cycle per event; the command register lives elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none

module lsf_status_reg
  import lsf_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Configuration access
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [lsf_pkg::LSF_ADDR_W-1:0] cfg_addr_i,
  input wire logic [1:0] cfg_be_i,
  input wire logic [lsf_pkg::LSF_DATA_W-1:0] cfg_wdata_i,
  output logic cfg_hit_o,
  output logic cfg_rvalid_o,
  output logic [lsf_pkg::LSF_DATA_W-1:0] cfg_rdata_o,
  // Command enables
  input wire logic system_error_enable_i,
  input wire logic parity_response_enable_i,
  // Link events
  input wire logic poisoned_tlp_rx_i,
  input wire logic err_msg_tx_i,
  input wire logic cpl_unsupported_rx_i,
  input wire logic cpl_abort_rx_i,
  input wire logic cpl_abort_tx_i,
  input wire logic poisoned_cpl_data_rx_i,
  input wire logic write_poisoned_i,
  // Register value
  output logic [lsf_pkg::LSF_DATA_W-1:0] status_o
);

  import lsf_pkg::*;

  typedef struct packed {
    logic rvalid;
    logic [LSF_DATA_W-1:0] rdata;
  } lsf_port_state_type;

  lsf_port_state_type state_reg;
  lsf_port_state_type state_next;

  logic [LSF_DATA_W-1:0] flag_set;
  logic [LSF_DATA_W-1:0] flag_clear;
  logic [LSF_DATA_W-1:0] flags;
  logic [LSF_DATA_W-1:0] status_value;
  logic hit;

  function automatic logic addr_hit(input logic [LSF_ADDR_W-1:0] addr);
    addr_hit = (addr == LSF_STATUS_OFFSET);
  endfunction

  // ==========================================================
  // Event decode
  always_comb begin
    flag_set = LSF_ZERO;
    flag_set[LSF_POISONED_RX_BIT] = poisoned_tlp_rx_i;
    flag_set[LSF_ERR_MSG_SENT_BIT] = err_msg_tx_i & system_error_enable_i;
    flag_set[LSF_UNSUP_CPL_RX_BIT] = cpl_unsupported_rx_i;
    flag_set[LSF_CA_RX_BIT] = cpl_abort_rx_i;
    flag_set[LSF_CA_TX_BIT] = cpl_abort_tx_i;
    flag_set[LSF_DATA_POISON_BIT] = parity_response_enable_i
                                    & (poisoned_cpl_data_rx_i | write_poisoned_i);
  end

  // ==========================================================
  // Write-one-to-clear; every sticky flag sits in the upper byte lane
  assign hit = addr_hit(cfg_addr_i);
  assign cfg_hit_o = (cfg_rd_i | cfg_wr_i) & hit;

  always_comb begin
    flag_clear = LSF_ZERO;
    if (cfg_wr_i && hit && cfg_be_i[LSF_HI_BYTE_LANE]) begin
      flag_clear = cfg_wdata_i & LSF_STICKY_MASK;
    end
  end

  lsf_sticky_bank #(
    .WIDTH(LSF_DATA_W)
  ) u_flags (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .set_i(flag_set),
    .clear_i(flag_clear),
    .flags_o(flags)
  );

  // ==========================================================
  // Read value: sticky bits plus constants, writes never reach the rest
  assign status_value = (flags & LSF_STICKY_MASK) | LSF_CONST_VALUE;
  assign status_o = status_value;

  always_comb begin
    state_next = state_reg;
    state_next.rvalid = cfg_rd_i;
    if (cfg_rd_i) begin
      // Unmapped offsets read as zero so the caller may merge other registers
      state_next.rdata = hit ? status_value : LSF_ZERO;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cfg_rvalid_o = state_reg.rvalid;
  assign cfg_rdata_o = state_reg.rdata;

  // ==========================================================
  // Checks
  a_poison_rx_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    poisoned_tlp_rx_i |=> status_o[LSF_POISONED_RX_BIT])
    else $error("poisoned TLP did not set flag");

  a_err_msg_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(status_o[LSF_ERR_MSG_SENT_BIT]) && status_o[LSF_ERR_MSG_SENT_BIT]
    |-> $past(err_msg_tx_i) && $past(system_error_enable_i))
    else $error("error message flag set without enabled cause");

  a_err_msg_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    err_msg_tx_i && system_error_enable_i |=> status_o[LSF_ERR_MSG_SENT_BIT])
    else $error("error message flag not set");

  a_unsup_cpl_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cpl_unsupported_rx_i |=> status_o[LSF_UNSUP_CPL_RX_BIT])
    else $error("unsupported completion flag not set");

  a_abort_rx_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cpl_abort_rx_i |=> status_o[LSF_CA_RX_BIT])
    else $error("received abort flag not set");

  a_abort_tx_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cpl_abort_tx_i |=> status_o[LSF_CA_TX_BIT])
    else $error("signaled abort flag not set");

  a_data_poison_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(status_o[LSF_DATA_POISON_BIT]) && status_o[LSF_DATA_POISON_BIT]
    |-> $past(parity_response_enable_i)
        && ($past(poisoned_cpl_data_rx_i) || $past(write_poisoned_i)))
    else $error("data poison flag set without enabled cause");

  a_data_poison_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    parity_response_enable_i && (poisoned_cpl_data_rx_i || write_poisoned_i)
    |=> status_o[LSF_DATA_POISON_BIT])
    else $error("data poison flag not set");

  a_const_fields: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_o[LSF_DEVSEL_HI_BIT:LSF_DEVSEL_LO_BIT] == LSF_DEVSEL_VALUE
    && !status_o[LSF_BACK_TO_BACK_BIT] && !status_o[LSF_FAST_BUS_BIT]
    && !status_o[LSF_INT_STATUS_BIT])
    else $error("hardwired field not zero");

  a_cap_chain_one: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_rd_i && hit |=> cfg_rvalid_o && cfg_rdata_o[LSF_CAP_CHAIN_BIT])
    else $error("capability chain bit not read as one");

  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_rvalid_o |-> !cfg_rdata_o[LSF_RSVD6_BIT] && cfg_rdata_o[2:0] == 3'h0)
    else $error("reserved bits not zero");

  a_clear_one: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_wr_i && hit && cfg_be_i[LSF_HI_BYTE_LANE]
    && cfg_wdata_i[LSF_CA_TX_BIT] && !cpl_abort_tx_i
    |=> !status_o[LSF_CA_TX_BIT])
    else $error("write one did not clear flag");

  a_sticky_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    status_o[LSF_POISONED_RX_BIT]
    && !(cfg_wr_i && hit && cfg_be_i[LSF_HI_BYTE_LANE] && cfg_wdata_i[LSF_POISONED_RX_BIT])
    |=> status_o[LSF_POISONED_RX_BIT])
    else $error("sticky flag lost without clear");

  a_reset_value: assert property (@(posedge core_clk_i)
    $fell(rst_i) |-> status_o == LSF_RESET_VALUE)
    else $error("reset value wrong");

  a_rvalid_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_rd_i |=> cfg_rvalid_o)
    else $error("read not answered next cycle");

  a_rvalid_single: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !cfg_rd_i |=> !cfg_rvalid_o)
    else $error("read valid without a read");

  a_rdata_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !cfg_rd_i |=> $stable(cfg_rdata_o))
    else $error("read data changed without a read");

  a_miss_read_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_rd_i && !hit |=> cfg_rdata_o == LSF_ZERO)
    else $error("unmapped read not zero");

  a_set_wins_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cpl_abort_rx_i && cfg_wr_i && hit && cfg_be_i[LSF_HI_BYTE_LANE]
    && cfg_wdata_i[LSF_CA_RX_BIT] |=> status_o[LSF_CA_RX_BIT])
    else $error("event lost to a clear in the same cycle");

  a_low_lane_keeps: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cfg_wr_i && !cfg_be_i[LSF_HI_BYTE_LANE] && status_o[LSF_CA_RX_BIT]
    |=> status_o[LSF_CA_RX_BIT])
    else $error("low lane write cleared a flag");

endmodule

`default_nettype wire

// ==== verification/lsf_link_partner.sv ====
/*
  Link partner model: turns a request mask from the bench into event pulses.
  Assumes the same clock as the status register.
*/
`timescale 1ns/1ps
`default_nettype none

module lsf_link_partner (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Bench request: bit order tlp, msg, ur, ca_rx, ca_tx, cpl, write
  input wire logic [6:0] fire_i,
  // Event pulses
  output logic [6:0] event_o
);
  // ==========================================================
  // Pulses
  // Registered copy of the request one cycle late, so a request held high stays a level
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      event_o <= 7'h00;
    end else begin
      event_o <= fire_i;
    end
  end
endmodule
`default_nettype wire

// ==== verification/lsf_status_reg_tb.sv ====
/*
  Self-checking bench for the link status flags register.
  Assumes lsf_pkg and the partner model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module lsf_status_reg_tb;
  import lsf_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cfg_rd_i = 1'b0;
  logic cfg_wr_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [1:0] cfg_be_i = 2'h0;
  logic [15:0] cfg_wdata_i = 16'h0000;
  logic sys_en = 1'b0;
  logic par_en = 1'b0;
  logic [6:0] fire = 7'h00;
  logic [6:0] ev;
  logic cfg_hit_o;
  logic cfg_rvalid_o;
  logic [15:0] cfg_rdata_o;
  logic [15:0] status_o;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int bitpos [7] = '{15, 14, 13, 12, 11, 8, 8};

  // ==========================================================
  // Clock, timeout
  initial forever #10 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      summarize();
    end
  end

  lsf_link_partner lsf_link_partner_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .fire_i(fire), .event_o(ev));
  lsf_status_reg lsf_status_reg_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
    .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_hit_o(cfg_hit_o),
    .cfg_rvalid_o(cfg_rvalid_o), .cfg_rdata_o(cfg_rdata_o),
    .system_error_enable_i(sys_en), .parity_response_enable_i(par_en),
    .poisoned_tlp_rx_i(ev[0]), .err_msg_tx_i(ev[1]), .cpl_unsupported_rx_i(ev[2]),
    .cpl_abort_rx_i(ev[3]), .cpl_abort_tx_i(ev[4]), .poisoned_cpl_data_rx_i(ev[5]),
    .write_poisoned_i(ev[6]), .status_o(status_o));

  // ==========================================================
  // Tasks
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Read data is compared in the cycle that rvalid stands
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk_i);
    cfg_rd_i <= 1'b1;
    cfg_addr_i <= a;
    @(negedge core_clk_i);
    chk("hit", {15'h0, cfg_hit_o}, {15'h0, a == LSF_STATUS_OFFSET});
    @(posedge core_clk_i);
    cfg_rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk("rvalid", {15'h0, cfg_rvalid_o}, 16'h0001);
    chk("rdata", cfg_rdata_o, exp);
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("rvalid_low", {15'h0, cfg_rvalid_o}, 16'h0000);
    chk("rdata_hold", cfg_rdata_o, exp);
  endtask

  task automatic wr(input logic [15:0] d, input logic [1:0] be);
    @(posedge core_clk_i);
    cfg_wr_i <= 1'b1;
    cfg_addr_i <= LSF_STATUS_OFFSET;
    cfg_be_i <= be;
    cfg_wdata_i <= d;
    @(negedge core_clk_i);
    chk("wr_hit", {15'h0, cfg_hit_o}, 16'h0001);
    @(posedge core_clk_i);
    cfg_wr_i <= 1'b0;
  endtask

  // Partner pulse takes one edge, the flag one more
  task automatic fire_ev(input logic [6:0] m);
    @(posedge core_clk_i);
    fire <= m;
    @(posedge core_clk_i);
    fire <= 7'h00;
    repeat (2) @(posedge core_clk_i);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(LSF_STATUS_OFFSET, 16'h0010);
    rd(8'h04, 16'h0000);
    // Enables low: bits 14 and 8 must stay clear, bit 15 still sets
    fire_ev(7'h7f);
    rd(LSF_STATUS_OFFSET, 16'hb810);
    wr(16'hffff, 2'b01);
    wr(16'h06ff, 2'b11);
    rd(LSF_STATUS_OFFSET, 16'hb810);
    wr(16'hf900, 2'b10);
    rd(LSF_STATUS_OFFSET, 16'h0010);
    // Each event alone with enables high, then a write-one clear
    @(posedge core_clk_i);
    sys_en <= 1'b1;
    par_en <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      fire_ev(7'h01 << i);
      rd(LSF_STATUS_OFFSET, 16'h0010 | (16'h0001 << bitpos[i]));
      chk("status", status_o, 16'h0010 | (16'h0001 << bitpos[i]));
      wr(16'h0001 << bitpos[i], 2'b10);
      @(negedge core_clk_i);
      chk("cleared", status_o, 16'h0010);
    end
    // Event and write-one clear meet at one edge: the event must survive
    fork
      fire_ev(7'h08);
      begin
        @(posedge core_clk_i);
        wr(16'h1000, 2'b10);
      end
    join
    rd(LSF_STATUS_OFFSET, 16'h1010);
    wr(16'h1000, 2'b10);
    rd(LSF_STATUS_OFFSET, 16'h0010);
    summarize();
  end
endmodule
`default_nettype wire
